// file: design/cfg_out_params.svh
`ifndef CFG_OUT_PARAMS_SVH
`define CFG_OUT_PARAMS_SVH

// ----------------------------------------
// storage geometry
// ----------------------------------------
`define CFG_ADDR_W        6
`define CFG_MEM_WORDS     64
`define CFG_BLK_SHIFT     4
`define CFG_TC            6'h3f
`define CFG_PAD_WORD      8'hff

// ----------------------------------------
// timing counts in source-clock periods / mclk cycles
// ----------------------------------------
`define CFG_TRAIL_CYC     4'h8
`define CFG_OSC_DIV_DEF   4'h1
`define CFG_OSC_DIV_SLOW  4'h7
`define CFG_DECOMP_WAIT   4'h3

// ----------------------------------------
// synchronised pin vector positions
// ----------------------------------------
`define PIN_EXTCLK        0
`define PIN_CE            1
`define PIN_OE            2
`define PIN_CF            3
`define PIN_BUSY          4
`define PIN_REV_LO        5
`define PIN_REV_HI        6
`define PIN_SEL           7
`define PIN_JTAG          8
`define PIN_W             9

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define REG_CTRL          8'h00
`define REG_STATUS        8'h04
`define REG_MEM_ADDR      8'h08
`define REG_MEM_DATA      8'h0c
`define REG_REV_CFG0      8'h10
`define REG_REV_CFG3      8'h1c

// ----------------------------------------
// control register fields
// ----------------------------------------
`define CTRL_SRC_SYNC_CLOCK_OUT_EN    0
`define CTRL_SRC_OSC      1
`define CTRL_OSC_SLOW     2
`define CTRL_DECOMP       3
`define CTRL_PARALLEL     4
`define CTRL_REV_EN       5
`define CTRL_REV_LO       8
`define CTRL_REV_HI       9
`define CTRL_RST          10'h001

// revision config: [5:0] last content word offset, [9:8] blocks minus one
`define REV_CFG_RST       10'h30f

// ----------------------------------------
// axi responses
// ----------------------------------------
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// file: design/cfg_out_pkg.sv
package cfg_out_pkg;
`include "cfg_out_params.svh"

  // one-hot sequencer states
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01, // held reset or standby
    ST_RUN   = 5'h02, // streaming words
    ST_TRAIL = 5'h04, // clock tail after enable rises
    ST_END   = 5'h08, // revision end address reached
    ST_TC    = 5'h10  // terminal count reached
  } seq_state_t;

  // whole module state
  typedef struct packed {
    logic [`PIN_W-1:0]                  s1;
    logic [`PIN_W-1:0]                  s2;
    logic [`PIN_W-1:0]                  prev;
    logic                               boot;
    logic [3:0]                         osc_cnt;
    logic                               osc_lvl;
    logic                               src_prev;
    seq_state_t                         state;
    logic [3:0]                         trail_cnt;
    logic                               gate;
    logic                               taken;
    logic [3:0]                         dcnt;
    logic                               dready;
    logic [`CFG_ADDR_W-1:0]             addr;
    logic [1:0]                         rev;
    logic [7:0]                         data_out;
    logic                               data_oe;
    logic                               clk_out;
    logic                               clk_oe;
    logic                               ceo_n;
    logic [9:0]                         ctrl;
    logic [`CFG_ADDR_W-1:0]             mem_addr;
    logic [3:0][9:0]                    rev_cfg;
    logic [`CFG_MEM_WORDS-1:0][7:0]     mem;
    logic                               awready;
    logic                               wready;
    logic                               aw_hold;
    logic                               w_hold;
    logic [7:0]                         aw_addr;
    logic [31:0]                        w_data;
    logic [3:0]                         w_strb;
    logic                               bvalid;
    logic [1:0]                         bresp;
    logic                               arready;
    logic                               rvalid;
    logic [31:0]                        rdata;
    logic [1:0]                         rresp;
  } cfg_out_state_t;

endpackage

// file: design/config_prom_output_control.sv
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
// What this block does
// [RULE_01] output clock from pin or oscillator
// [RULE_02] data valid at output clock rise
// [RULE_03] clock toggles only when enabled, unreset
// [RULE_04] enable rising: eight trailing clocks then stop
// [RULE_05] reset falling stops clock immediately
// [RULE_06] disabled clock pin floats; pulled up outside
// [RULE_07] cascade: exhausted device stops, enables next; cascade stays high at revision end (ST_END), low only at terminal count
// [RULE_08] busy freezes address, clock keeps running
// [RULE_09] target raises busy; resume after release
// [RULE_10] busy ignored when decompressing
// [RULE_11] target is slave clocked by our clock
// [RULE_12] decompression gives slower gated clock
// [RULE_13] decompressed data missing: clock pin floats
// [RULE_14] four revisions of whole blocks
// [RULE_15] unused block tail reads all ones
// [RULE_16] two-bit revision number 00 to 11
// [RULE_17] selection from pins or internal bits
// [RULE_18] sample selection at listed events
// [RULE_19] stream chosen revision after sampling
// [RULE_20] oscillator default or slow frequency
// [RULE_21] address reset to revision bank start
// [RULE_22] terminal count stops, floats, cascade low
// [RULE_23] reset or disable: counter reset, floats
// [RULE_24] gate clock only while source low
module config_prom_output_control
  import cfg_out_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // configuration pins from the target side
  input  wire logic        ext_clk,
  input  wire logic        chip_enable_n,
  input  wire logic        oe_reset_n,
  input  wire logic        configure_pulse_n,
  input  wire logic        busy,
  input  wire logic [1:0]  revision_select_pins,
  input  wire logic        select_source_choice,
  input  wire logic        jtag_config_req,
  // configuration outputs
  output logic [7:0]       data_out,
  output logic             data_oe,
  output logic             src_sync_clock_out,
  output logic             src_sync_clock_oe,
  output logic             cascade_enable_out_n,
  // axi4-lite write channels
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read channels
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------

  // first word of a revision bank, or zero without revisioning
  function automatic logic [`CFG_ADDR_W-1:0] bank_base(input logic [1:0] rv, input logic en);
    bank_base = en ? {rv, 4'h0} : '0; // [RULE_21]
  endfunction

  // word fetch; beyond the revision content the block tail reads as ones
  function automatic logic [7:0] fetch(input cfg_out_state_t s, input logic [`CFG_ADDR_W-1:0] a);
    logic [`CFG_ADDR_W-1:0] last;
    last  = bank_base(s.rev, s.ctrl[`CTRL_REV_EN]) + s.rev_cfg[s.rev][5:0];
    fetch = (s.ctrl[`CTRL_REV_EN] && a > last) ? `CFG_PAD_WORD : s.mem[a]; // [RULE_15]
  endfunction

  // last address of the selected revision, clamped to terminal count
  function automatic logic [`CFG_ADDR_W-1:0] end_addr(input cfg_out_state_t s);
    logic [7:0] ea;
    ea = 8'(bank_base(s.rev, 1'b1)) + 8'({s.rev_cfg[s.rev][9:8] + 3'h1, 4'h0}) - 8'h01; // [RULE_14]
    if (!s.ctrl[`CTRL_REV_EN] || ea > 8'(`CFG_TC)) begin
      end_addr = `CFG_TC;
    end else begin
      end_addr = ea[`CFG_ADDR_W-1:0];
    end
  endfunction

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        merge[8*i +: 8] = nw[8*i +: 8];
      end
    end
  endfunction

  cfg_out_state_t r;    // registered state
  cfg_out_state_t n;    // next state

  // ----------------------------------------
  // combinational next state
  // ----------------------------------------
  always_comb begin
    logic                   lvl;      // selected source clock level
    logic                   rise;
    logic                   fall;
    logic                   ce_low;
    logic                   oe_high;
    logic                   ce_rise;
    logic                   oe_fall;
    logic                   cf_rise;
    logic                   jt_rise;
    logic                   busy_on;
    logic                   ready;
    logic [`CFG_ADDR_W-1:0] ea;
    logic [3:0]             div;
    logic [31:0]            rd;
    logic [31:0]            wv;
    lvl     = 1'b0;
    rise    = 1'b0;
    fall    = 1'b0;
    ce_low  = 1'b0;
    oe_high = 1'b0;
    ce_rise = 1'b0;
    oe_fall = 1'b0;
    cf_rise = 1'b0;
    jt_rise = 1'b0;
    busy_on = 1'b0;
    ready   = 1'b0;
    ea      = '0;
    div     = '0;
    rd      = '0;
    wv      = '0;
    n       = r;

    // pin synchronisers: logic reads s2 and its delayed copy prev, never s1
    n.s1   = {jtag_config_req, select_source_choice, revision_select_pins, busy,
              configure_pulse_n, oe_reset_n, chip_enable_n, ext_clk};
    n.s2   = r.s1;
    n.prev = r.s2;

    // internal oscillator divided down from mclk
    div = r.ctrl[`CTRL_OSC_SLOW] ? `CFG_OSC_DIV_SLOW : `CFG_OSC_DIV_DEF; // [RULE_20]
    if (r.osc_cnt >= div) begin
      n.osc_cnt = '0;
      n.osc_lvl = ~r.osc_lvl;
    end else begin
      n.osc_cnt = r.osc_cnt + 4'h1;
    end

    // source clock choice fixed by the programmed option
    lvl        = r.ctrl[`CTRL_SRC_OSC] ? r.osc_lvl : r.s2[`PIN_EXTCLK]; // [RULE_01]
    rise       = lvl & ~r.src_prev;
    fall       = ~lvl & r.src_prev;
    n.src_prev = lvl;

    // pin events on synchronised levels
    ce_low  = ~r.s2[`PIN_CE];
    oe_high = r.s2[`PIN_OE];
    ce_rise = r.s2[`PIN_CE] & ~r.prev[`PIN_CE];
    oe_fall = ~r.s2[`PIN_OE] & r.prev[`PIN_OE];
    cf_rise = r.s2[`PIN_CF] & ~r.prev[`PIN_CF];
    jt_rise = r.s2[`PIN_JTAG] & ~r.prev[`PIN_JTAG];

    // revision sampling events
    if (!r.boot || ce_rise || (oe_fall && ce_low) || (cf_rise && ce_low) || jt_rise) begin // [RULE_18]
      n.boot = 1'b1;
      n.rev  = r.s2[`PIN_SEL] ? r.ctrl[`CTRL_REV_HI:`CTRL_REV_LO] // [RULE_17]
                              : r.s2[`PIN_REV_HI:`PIN_REV_LO];    // [RULE_16]
    end

    // busy honoured only for uncompressed parallel output
    busy_on = r.ctrl[`CTRL_PARALLEL] & ~r.ctrl[`CTRL_DECOMP]; // [RULE_10]
    ready   = ~r.ctrl[`CTRL_DECOMP] | r.dready;
    ea      = end_addr(r);

    // sequencer
    case (r.state)
      ST_IDLE: begin
        // held reset: counter at bank start, outputs floating
        n.addr    = bank_base(n.rev, r.ctrl[`CTRL_REV_EN]); // [RULE_23]
        n.gate    = 1'b0;
        n.taken   = 1'b0;
        n.dready  = 1'b0;
        n.dcnt    = '0;
        n.data_oe = 1'b0;
        n.ceo_n   = 1'b1;
        if (oe_high && ce_low) begin
          n.state = ST_RUN; // [RULE_19]
        end
      end
      ST_RUN: begin
        if (!oe_high) begin
          // reset falling: no tail, clock off at once
          n.state = ST_IDLE; // [RULE_05]
          n.gate  = 1'b0;
        end else if (ce_rise) begin
          n.state     = ST_TRAIL; // [RULE_04]
          n.trail_cnt = '0;
        end else if (!r.s2[`PIN_CF]) begin
          // configure pulse low holds the counter at bank start
          n.addr  = bank_base(n.rev, r.ctrl[`CTRL_REV_EN]); // [RULE_21]
          n.taken = 1'b0;
        end else begin
          // decompressor stand-in: each word needs a few source periods
          if (r.ctrl[`CTRL_DECOMP] && !r.dready && fall) begin
            n.dcnt = r.dcnt + 4'h1;
            if (r.dcnt + 4'h1 >= `CFG_DECOMP_WAIT) begin
              n.dready = 1'b1; // [RULE_12]
            end
          end
          if (rise && r.gate) begin
            n.taken = 1'b1;
          end
          // advance only on a falling edge so data is stable at the next rise
          if (fall && r.taken && !(busy_on && r.s2[`PIN_BUSY])) begin // [RULE_08] [RULE_09]
            n.taken  = 1'b0;
            n.dready = 1'b0;
            n.dcnt   = '0;
            if (r.addr == `CFG_TC) begin
              n.state = ST_TC; // [RULE_22]
            end else if (r.addr == ea) begin
              n.state = ST_END; // [RULE_07]
            end else begin
              n.addr = r.addr + 6'h01; // [RULE_02]
            end
          end
          // gate moves only while the source is low, never a runt
          if (!lvl) begin
            n.gate = r.ctrl[`CTRL_SRC_SYNC_CLOCK_OUT_EN] & ready; // [RULE_24] [RULE_13]
          end
        end
        n.data_oe = 1'b1;
        n.ceo_n   = 1'b1;
      end
      ST_TRAIL: begin
        // tail of eight clocks with data frozen
        if (!oe_high) begin
          n.state = ST_IDLE; // [RULE_05]
          n.gate  = 1'b0;
        end else if (fall) begin
          n.trail_cnt = r.trail_cnt + 4'h1;
          if (r.trail_cnt + 4'h1 >= `CFG_TRAIL_CYC) begin
            // gate closes in idle, so the eighth low phase is still driven
            n.state = ST_IDLE; // [RULE_04]
          end
        end
      end
      ST_END, ST_TC: begin
        // data exhausted: float clock and data, cascade low only at terminal count
        n.gate    = 1'b0; // [RULE_07]
        n.data_oe = 1'b0;
        n.ceo_n   = (r.state == ST_END); // [RULE_22]
        if (!oe_high || !ce_low) begin
          n.state = ST_IDLE; // [RULE_23]
        end else if (!r.s2[`PIN_CF]) begin
          n.state = ST_RUN;
          n.addr  = bank_base(n.rev, r.ctrl[`CTRL_REV_EN]);
        end
      end
      default: begin
        n.state = ST_IDLE;
      end
    endcase

    // pin drivers; the clock pin follows the source only when gated on
    n.data_out = fetch(r, n.addr); // [RULE_19]
    n.clk_out  = n.gate & lvl;     // [RULE_03]
    n.clk_oe   = n.gate;           // [RULE_06]

    // ----------------------------------------
    // axi4-lite write path
    // ----------------------------------------
    if (awvalid && r.awready) begin
      n.aw_hold = 1'b1;
      n.aw_addr = awaddr;
    end
    if (wvalid && r.wready) begin
      n.w_hold = 1'b1;
      n.w_data = wdata;
      n.w_strb = wstrb;
    end
    if (r.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    if (r.aw_hold && r.w_hold && !r.bvalid) begin
      n.aw_hold = 1'b0;
      n.w_hold  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = `RESP_OKAY;
      case (r.aw_addr)
        `REG_CTRL: begin
          wv     = merge({22'h0, r.ctrl}, r.w_data, r.w_strb);
          n.ctrl = wv[9:0];
        end
        `REG_MEM_ADDR: begin
          wv         = merge({26'h0, r.mem_addr}, r.w_data, r.w_strb);
          n.mem_addr = wv[`CFG_ADDR_W-1:0];
        end
        `REG_MEM_DATA: begin
          // sequential loading of the store, pointer steps per write
          if (r.w_strb[0]) begin
            n.mem[r.mem_addr] = r.w_data[7:0];
          end
          n.mem_addr = r.mem_addr + 6'h01;
        end
        default: begin
          if (r.aw_addr >= `REG_REV_CFG0 && r.aw_addr <= `REG_REV_CFG3 && r.aw_addr[1:0] == 2'h0) begin
            wv                         = merge({22'h0, r.rev_cfg[r.aw_addr[3:2]]}, r.w_data, r.w_strb);
            n.rev_cfg[r.aw_addr[3:2]]  = wv[9:0];
          end else begin
            n.bresp = `RESP_SLVERR;
          end
        end
      endcase
    end
    n.awready = ~n.aw_hold & ~n.bvalid;
    n.wready  = ~n.w_hold & ~n.bvalid;

    // ----------------------------------------
    // axi4-lite read path
    // ----------------------------------------
    if (r.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    if (arvalid && r.arready) begin
      n.rvalid = 1'b1;
      n.rresp  = `RESP_OKAY;
      case (araddr)
        `REG_CTRL:     rd = {22'h0, r.ctrl};
        `REG_STATUS:   rd = {12'h0, r.s2[`PIN_BUSY], r.ceo_n, r.clk_oe, r.data_oe, r.rev, r.addr, 3'h0, r.state};
        `REG_MEM_ADDR: rd = {26'h0, r.mem_addr};
        `REG_MEM_DATA: rd = {24'h0, r.mem[r.mem_addr]};
        default: begin
          if (araddr >= `REG_REV_CFG0 && araddr <= `REG_REV_CFG3 && araddr[1:0] == 2'h0) begin
            rd = {22'h0, r.rev_cfg[araddr[3:2]]};
          end else begin
            n.rresp = `RESP_SLVERR;
          end
        end
      endcase
      n.rdata = rd;
    end
    n.arready = ~n.rvalid;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      r          <= '0;
      r.state    <= ST_IDLE;
      r.ceo_n    <= 1'b1;
      r.ctrl     <= `CTRL_RST;
      r.rev_cfg  <= {4{`REV_CFG_RST}};
      r.mem      <= {`CFG_MEM_WORDS{`CFG_PAD_WORD}};
      r.awready  <= 1'b1;
      r.wready   <= 1'b1;
      r.arready  <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // outputs straight from the state flops
  assign data_out             = r.data_out;
  assign data_oe              = r.data_oe;
  assign src_sync_clock_out   = r.clk_out;
  assign src_sync_clock_oe    = r.clk_oe;
  assign cascade_enable_out_n = r.ceo_n;
  assign awready              = r.awready;
  assign wready               = r.wready;
  assign bresp                = r.bresp;
  assign bvalid               = r.bvalid;
  assign arready              = r.arready;
  assign rdata                = r.rdata;
  assign rresp                = r.rresp;
  assign rvalid               = r.rvalid;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_reset_kills_clock: assert property ( // [RULE_05]
    (r.state == ST_RUN && !r.s2[`PIN_OE]) |=> !r.clk_oe ##1 !r.clk_oe)
    else $error("clock still enabled after reset fell");

  a_busy_freezes_addr: assert property ( // [RULE_08]
    (r.state == ST_RUN && r.ctrl[`CTRL_PARALLEL] && !r.ctrl[`CTRL_DECOMP] && r.s2[`PIN_BUSY]
     && r.s2[`PIN_CF] && r.s2[`PIN_OE] && !r.s2[`PIN_CE]) |=> $stable(r.addr))
    else $error("address moved while busy");

  a_data_stable_rise: assert property ( // [RULE_02]
    $rose(r.clk_out) |-> $stable(r.data_out))
    else $error("data changed at output clock rise");

  a_gate_on_low: assert property ( // [RULE_24]
    $rose(r.clk_oe) |-> !r.clk_out)
    else $error("clock gated on while high");

  a_tc_cascade_low: assert property ( // [RULE_22]
    (r.state == ST_TC) |=> (!r.ceo_n && !r.data_oe && !r.clk_oe))
    else $error("terminal count outputs wrong");

  a_idle_floats: assert property ( // [RULE_23]
    (r.state == ST_IDLE && $past(r.state) == ST_IDLE) |-> (r.ceo_n && !r.data_oe && !r.clk_oe))
    else $error("idle outputs not floating");

  a_trail_bounded: assert property ( // [RULE_04]
    (r.state == ST_TRAIL) |-> (r.trail_cnt < `CFG_TRAIL_CYC))
    else $error("trailing clocks exceed eight");

  a_toggle_when_on: assert property ( // [RULE_03]
    $changed(r.clk_out) |-> (r.state == ST_RUN || r.state == ST_TRAIL || $fell(r.clk_out)))
    else $error("clock toggled while disabled");

  a_pad_all_ones: assert property ( // [RULE_15]
    (r.ctrl[`CTRL_REV_EN] && r.state == ST_RUN
     && r.addr > bank_base(r.rev, 1'b1) + r.rev_cfg[r.rev][5:0]) |=> (r.data_out == `CFG_PAD_WORD || $changed(r.addr)))
    else $error("padding not all ones");

  a_decomp_no_clock: assert property ( // [RULE_13]
    (r.state == ST_RUN && r.ctrl[`CTRL_DECOMP] && !r.dready && !r.src_prev) |=> !r.clk_oe)
    else $error("clock driven without decompressed data");

endmodule

// file: dv/cfg_target_model.sv
`timescale 1ns/1ps
// target configuration logic as a slave clocked from our clock pin
module cfg_target_model (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_b,
  // configuration pins
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe,
  input  wire logic       clk_out,
  input  wire logic       clk_oe,
  output logic            busy,
  // bench control and capture
  input  wire logic       stall,
  input  wire logic       listen,
  output logic            got,
  output logic [7:0]      word
);
  logic pin_q;                          // pin level one cycle ago
  wire  pin = clk_oe ? clk_out : 1'b1;  // pull-up holds a floated pin high
  // capture at pin rise; busy moves just after a rise so it lands before the next fall
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pin_q <= 1'b1;
      busy  <= 1'b0;
      got   <= 1'b0;
      word  <= 8'h00;
    end else begin
      pin_q <= pin;
      got   <= 1'b0;
      if (pin && !pin_q && clk_oe) begin  // our config clock is the device pin
        if (listen && !busy && data_oe) begin
          got  <= 1'b1;
          word <= data_out;
        end
        busy <= stall;  // raised only when we cannot take data
      end
    end
  end
endmodule

// file: dv/config_prom_output_control_tb.sv
`timescale 1ns/1ps
`include "cfg_out_params.svh"
module config_prom_output_control_tb;
  logic        mclk, rst_b, ext_clk, chip_enable_n, oe_reset_n, configure_pulse_n, busy;
  logic        select_source_choice, jtag_config_req, data_oe, src_sync_clock_out, src_sync_clock_oe;
  logic        cascade_enable_out_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, stall, listen, got, pc;
  logic [1:0]  revision_select_pins, bresp, rresp;
  logic [7:0]  data_out, awaddr, araddr, word, v, v0;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [33:0] exp_r[$];  // expected {resp, data} per bus answer
  logic [7:0]  exp_w[$];  // expected words at the target
  int          error_cnt, check_count, n, falls;
  // ----------------
  // helpers
  // ----------------
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task cmp_reg(input logic [33:0] e, input logic [33:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: exp %h got %h", $time, e, g);
    end
  endtask
  task cmp_pin(input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: exp %h got %h", $time, e, g);
    end
  endtask
  task tick(input int k);
    repeat (k) @(posedge mclk);
  endtask
  task hang(input int lim);  // a used-up bound ends the run
    if (n >= lim) begin
      error_cnt++;
      print_verdict;
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_r.push_back({r, 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;  // bready stays high between writes
    end
    hang(50);
  endtask
  task rd(input logic [7:0] a, input logic [33:0] e);
    exp_r.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;  // rready stays high between reads
    end
    hang(50);
  endtask
  // ----------------
  // structure
  // ----------------
  config_prom_output_control DUT (.mclk(mclk), .rst_b(rst_b), .ext_clk(ext_clk), .chip_enable_n(chip_enable_n),
    .oe_reset_n(oe_reset_n), .configure_pulse_n(configure_pulse_n), .busy(busy),
    .revision_select_pins(revision_select_pins), .select_source_choice(select_source_choice),
    .jtag_config_req(jtag_config_req), .data_out(data_out), .data_oe(data_oe),
    .src_sync_clock_out(src_sync_clock_out), .src_sync_clock_oe(src_sync_clock_oe),
    .cascade_enable_out_n(cascade_enable_out_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));
  cfg_target_model target (.mclk(mclk), .rst_b(rst_b), .data_out(data_out), .data_oe(data_oe),
    .clk_out(src_sync_clock_out), .clk_oe(src_sync_clock_oe), .busy(busy), .stall(stall), .listen(listen),
    .got(got), .word(word));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin  // source clock, phase unrelated to mclk
    ext_clk = 1'b0;
    #7;
    forever #80 ext_clk = ~ext_clk;
  end
  initial begin  // hang guard
    tick(100000);
    error_cnt++;
    print_verdict;
  end
  // answers are matched against the oldest note
  always @(posedge mclk) begin
    if (bvalid && bready) cmp_reg(exp_r.pop_front(), {bresp, 32'h0});
    if (rvalid && rready) cmp_reg(exp_r.pop_front(), {rresp, rdata});
    if (got && exp_w.size() > 0) cmp_pin(exp_w.pop_front(), word);
  end
  // ----------------
  // main sequence
  // ----------------
  initial begin
    {rst_b, chip_enable_n, oe_reset_n, configure_pulse_n, select_source_choice, jtag_config_req} = 6'h14;
    {awvalid, wvalid, bready, arvalid, rready, stall, listen} = 7'h14;
    {awaddr, araddr, wdata, wstrb, revision_select_pins} = {16'h0, 32'h0, 4'hf, 2'h1};
    error_cnt = 0;
    check_count = 0;
    v = 8'($urandom(32'h2d6d3e22));
    tick(5);
    rst_b <= 1'b1;
    tick(2);
    rd(`REG_CTRL, {`RESP_OKAY, 22'h0, `CTRL_RST});
    rd(`REG_REV_CFG0, {`RESP_OKAY, 22'h0, `REV_CFG_RST});
    rd(8'h40, {`RESP_SLVERR, 32'h0});
    wr(8'h44, 32'h0, `RESP_SLVERR);
    $display("test registers done");
    wr(`REG_MEM_ADDR, 32'h10, `RESP_OKAY);  // bank one start
    for (int i = 0; i < 7; i++) begin
      v = 8'($urandom) & 8'h7f;  // never all ones, so a padded word stands out
      if (i == 0) v0 = v;
      exp_w.push_back(i < 6 ? v : `CFG_PAD_WORD);
      wr(`REG_MEM_DATA, {24'h0, v}, `RESP_OKAY);
    end
    wr(`REG_REV_CFG0 + 8'h04, 32'h305, `RESP_OKAY);  // revision one content ends at offset 5
    wr(`REG_CTRL, 32'h31, `RESP_OKAY);  // clock out, parallel, revisions
    chip_enable_n <= 1'b0;  // enable rise samples pins = 1
    tick(6);
    chip_enable_n <= 1'b1;
    tick(6);
    oe_reset_n <= 1'b1;
    listen <= 1'b1;
    tick(2);
    chip_enable_n <= 1'b0;  // stream from bank one
    for (n = 0; n < 3000 && exp_w.size() > 0; n++) begin
      tick(1);
      if (n % 24 == 0) stall <= 1'($urandom);  // busy holds word, clock runs
    end
    hang(3000);
    stall <= 1'b0;
    $display("test stream done");
    @(posedge ext_clk);
    tick(1);
    chip_enable_n <= 1'b1;
    falls = 0;
    pc = src_sync_clock_out;
    for (int i = 0; i < 400; i++) begin
      tick(1);
      if (pc && !src_sync_clock_out && src_sync_clock_oe) falls++;
      pc = src_sync_clock_out;
    end
    cmp_pin(8'h08, 8'(falls));
    cmp_pin(8'h00, {7'h0, src_sync_clock_oe});
    cmp_pin(8'h01, {6'h0, data_oe, cascade_enable_out_n});
    $display("test trailing clocks done");
    listen <= 1'b0;
    chip_enable_n <= 1'b0;
    for (n = 0; n < 200 && !(src_sync_clock_oe && src_sync_clock_out); n++) tick(1);
    hang(200);
    oe_reset_n <= 1'b0;  // while clock is high
    tick(6);
    cmp_pin(8'h00, {7'h0, src_sync_clock_oe});
    cmp_pin(8'h01, {6'h0, data_oe, cascade_enable_out_n});
    $display("test reset stop done");
    wr(`REG_CTRL, 32'h2b, `RESP_OKAY);  // oscillator source, decompression
    exp_w.push_back(v0);
    listen <= 1'b1;
    oe_reset_n <= 1'b1;
    for (n = 0; n < 400 && exp_w.size() > 0; n++) tick(1);  // clock floats until data ready
    hang(400);
    $display("test decompression done");
    print_verdict;
  end
endmodule
